// ---- psw_status_word.sv ----
// Overview of operation
// RULE1 - Carry set on carry or borrow, else cleared
// RULE2 - Half carry set on nibble carry or borrow
// RULE3 - Bits 5 and 1 are software-only flags
// RULE4 - Bank select bits 4:3 pick register bank
// RULE5 - Overflow on signed wrap of add/subtract
// RULE6 - Overflow when product exceeds 255
// RULE7 - Overflow on divide by zero
// RULE8 - Overflow cleared otherwise by those instructions
// RULE9 - Parity bit tracks accumulator odd ones
// RULE10 - Word at 0xd0, byte/bit access, resets zero
// RULE11 - Eight working registers per active bank
// RULE12 - Writes store all bits except parity
`include "psw_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module psw_status_word
    import psw_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Arithmetic unit report and accumulator
    input wire psw_alu_t alu_i,
    input wire logic [7:0] acc_i,
    // Register write port
    input wire psw_wr_t wr_i,
    // Working register number 0..7
    input wire logic [2:0] reg_num_i,
    // Status word read value
    output logic [7:0] status_flags_word_o,
    // Data address of the selected working register
    output logic [4:0] work_reg_addr_o,
    // Carry flag for the arithmetic unit
    output logic carry_flag_o
);
    // Stored flag bits
    logic carry_flag_reg;
    logic half_carry_flag_reg;
    logic user_flag_zero_reg;
    logic [1:0] reg_bank_select_reg;
    logic arith_wrap_flag_reg;
    logic user_flag_one_reg;
    logic parity_reg;
    // Arithmetic results
    logic [8:0] sum9;
    logic [4:0] nib5;
    logic sub_op;
    logic add_op;
    logic c_next;
    logic h_next;
    logic v_next;
    logic wrap_upd;
    logic cy_upd;
    // Write decode
    logic hit;
    logic [7:0] wmask;
    logic [7:0] wval;

    // Odd count of ones in a byte
    function automatic logic odd_ones(input logic [7:0] v);
        odd_ones = ^v;
    endfunction : odd_ones

    // Adder and subtractor with carry chain
    always_comb
    begin
        add_op = (alu_i.op == PSW_OP_ADD) || (alu_i.op == PSW_OP_ADD_WITH_CARRY_OP);
        sub_op = (alu_i.op == PSW_OP_SUBTRACT_WITH_BORROW_OP);
        // Carry in only for add-with-carry and subtract-with-borrow
        if (sub_op)
        begin
            sum9 = {1'b0, alu_i.a} - {1'b0, alu_i.b} - {8'h00, alu_i.cin};
            nib5 = {1'b0, alu_i.a[3:0]} - {1'b0, alu_i.b[3:0]} - {4'h0, alu_i.cin};
        end
        else
        begin
            sum9 = {1'b0, alu_i.a} + {1'b0, alu_i.b} + {8'h00, alu_i.cin & (alu_i.op == PSW_OP_ADD_WITH_CARRY_OP)};
            nib5 = {1'b0, alu_i.a[3:0]} + {1'b0, alu_i.b[3:0]} + {4'h0, alu_i.cin & (alu_i.op == PSW_OP_ADD_WITH_CARRY_OP)};
        end
        // Multiply and divide always clear both carries
        c_next = (add_op || sub_op) ? sum9[8] :
                 ((alu_i.op == PSW_OP_MUL) || (alu_i.op == PSW_OP_DIV)) ? 1'b0 : alu_i.carry_ext; // RULE1
        h_next = (add_op || sub_op) ? nib5[4] :
                 ((alu_i.op == PSW_OP_MUL) || (alu_i.op == PSW_OP_DIV)) ? 1'b0 : alu_i.half_ext; // RULE2
        cy_upd = alu_i.valid && (alu_i.op != PSW_OP_NONE);
        wrap_upd = alu_i.valid && (add_op || sub_op || alu_i.op == PSW_OP_MUL || alu_i.op == PSW_OP_DIV);
        // Signed wrap: operand signs agree (b inverted on subtract) but result differs
        case (alu_i.op)
            PSW_OP_ADD, PSW_OP_ADD_WITH_CARRY_OP: v_next = (alu_i.a[7] == alu_i.b[7]) && (sum9[7] != alu_i.a[7]); // RULE5
            PSW_OP_SUBTRACT_WITH_BORROW_OP: v_next = (alu_i.a[7] != alu_i.b[7]) && (sum9[7] != alu_i.a[7]); // RULE5
            PSW_OP_MUL: v_next = (alu_i.prod_hi != 8'h00); // RULE6
            PSW_OP_DIV: v_next = (alu_i.b == 8'h00); // RULE7
            default: v_next = 1'b0; // RULE8
        endcase
    end

    // Byte or bit write decode at the fixed address
    always_comb
    begin
        hit = (wr_i.addr == `PSW_ADDR); // RULE10
        wmask = 8'h00;
        wval = wr_i.wdata;
        if (hit && wr_i.byte_we)
            wmask = 8'hff;
        else if (hit && wr_i.bit_we)
        begin
            wmask = 8'h01 << wr_i.bit_sel;
            wval = {8{wr_i.wdata[0]}};
        end
        wmask[`PSW_PARITY_BIT] = 1'b0; // RULE12
    end

    // Carry and half carry: software write, then arithmetic update wins
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            carry_flag_reg <= 1'b0;
            half_carry_flag_reg <= 1'b0;
        end
        else if (cy_upd)
        begin
            carry_flag_reg <= c_next; // RULE1
            half_carry_flag_reg <= h_next; // RULE2
        end
        else
        begin
            if (wmask[`PSW_CARRY_BIT])
                carry_flag_reg <= wval[`PSW_CARRY_BIT]; // RULE12
            if (wmask[`PSW_HALF_BIT])
                half_carry_flag_reg <= wval[`PSW_HALF_BIT]; // RULE12
        end
    end

    // Overflow flag
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            arith_wrap_flag_reg <= 1'b0;
        else if (wrap_upd)
            arith_wrap_flag_reg <= v_next; // RULE8
        else if (wmask[`PSW_WRAP_BIT])
            arith_wrap_flag_reg <= wval[`PSW_WRAP_BIT]; // RULE12
    end

    // Software flags and bank select, never touched by hardware
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            user_flag_zero_reg <= 1'b0;
            user_flag_one_reg <= 1'b0;
            reg_bank_select_reg <= 2'h0;
        end
        else
        begin
            if (wmask[`PSW_USER0_BIT])
                user_flag_zero_reg <= wval[`PSW_USER0_BIT]; // RULE3
            if (wmask[`PSW_USER1_BIT])
                user_flag_one_reg <= wval[`PSW_USER1_BIT]; // RULE3
            if (wmask[`PSW_BANK_LO])
                reg_bank_select_reg[0] <= wval[`PSW_BANK_LO]; // RULE4
            if (wmask[`PSW_BANK_HI])
                reg_bank_select_reg[1] <= wval[`PSW_BANK_HI]; // RULE4
        end
    end

    // Parity follows the accumulator every cycle
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            parity_reg <= 1'b0;
        else
            parity_reg <= odd_ones(acc_i); // RULE9
    end

    // Registered outputs built from the stored flag registers and reg_num_i, one edge behind them
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            status_flags_word_o <= `PSW_RESET; // RULE10
            work_reg_addr_o <= 5'h00;
            carry_flag_o <= 1'b0;
        end
        else
        begin
            status_flags_word_o <= {carry_flag_reg, half_carry_flag_reg, user_flag_zero_reg,
                                    reg_bank_select_reg, arith_wrap_flag_reg, user_flag_one_reg, parity_reg};
            work_reg_addr_o <= {reg_bank_select_reg, reg_num_i}; // RULE11
            carry_flag_o <= carry_flag_reg;
        end
    end

    // Parity lags accumulator by exactly one edge
    a_parity_track: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        ##1 parity_reg == ^$past(acc_i)) else $error("parity wrong"); // RULE9
    // Carry after add matches ninth sum bit
    a_carry_add: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (alu_i.valid && alu_i.op == PSW_OP_ADD) |=> carry_flag_reg == ({1'b0, $past(alu_i.a)} + {1'b0, $past(alu_i.b)}) >> 8)
        else $error("carry wrong"); // RULE1
    // Half carry after plain add
    a_half_add: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (alu_i.valid && alu_i.op == PSW_OP_ADD) |=> half_carry_flag_reg == (({1'b0, $past(alu_i.a[3:0])} + {1'b0, $past(alu_i.b[3:0])}) >> 4))
        else $error("half carry wrong"); // RULE2
    // Multiply overflow equals nonzero high byte
    a_mul_wrap: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (alu_i.valid && alu_i.op == PSW_OP_MUL) |=> arith_wrap_flag_reg == ($past(alu_i.prod_hi) != 8'h00))
        else $error("multiply overflow wrong"); // RULE6
    // Divide by zero sets overflow
    a_div_zero: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (alu_i.valid && alu_i.op == PSW_OP_DIV && alu_i.b == 8'h00) |=> arith_wrap_flag_reg)
        else $error("divide overflow missing"); // RULE7
    // Signed add overflow
    a_add_wrap: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (alu_i.valid && alu_i.op == PSW_OP_ADD && alu_i.a == 8'h7f && alu_i.b == 8'h01) |=> arith_wrap_flag_reg)
        else $error("add overflow missing"); // RULE5
    // Overflow cleared by divide with nonzero divisor
    a_wrap_clear: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (alu_i.valid && alu_i.op == PSW_OP_DIV && alu_i.b != 8'h00) |=> !arith_wrap_flag_reg)
        else $error("overflow not cleared"); // RULE8
    // User flags hold without a write
    a_user_hold: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        !(wr_i.addr == `PSW_ADDR && (wr_i.byte_we || wr_i.bit_we)) |=> $stable(user_flag_zero_reg) && $stable(user_flag_one_reg))
        else $error("user flag changed"); // RULE3
    // Byte write lands in bank select
    a_bank_write: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (wr_i.addr == `PSW_ADDR && wr_i.byte_we) |=> reg_bank_select_reg == $past(wr_i.wdata[4:3]))
        else $error("bank select not written"); // RULE4
    // Working address follows bank one edge later
    a_work_addr: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        ##1 work_reg_addr_o == {$past(reg_bank_select_reg), $past(reg_num_i)})
        else $error("working address wrong"); // RULE11
endmodule : psw_status_word
`default_nettype wire

// ---- psw_regs.svh ----
`ifndef PSW_REGS_SVH
`define PSW_REGS_SVH
// Special function address of the status word
`define PSW_ADDR 8'hd0
// Reset value of the whole word
`define PSW_RESET 8'h00
// Field positions
`define PSW_CARRY_BIT 3'd7
`define PSW_HALF_BIT 3'd6
`define PSW_USER0_BIT 3'd5
`define PSW_BANK_HI 3'd4
`define PSW_BANK_LO 3'd3
`define PSW_WRAP_BIT 3'd2
`define PSW_USER1_BIT 3'd1
`define PSW_PARITY_BIT 3'd0
`endif

// ---- psw_pkg.sv ----
package psw_pkg;
    // Arithmetic operation classes from the arithmetic unit
    typedef enum logic [6:0]
    {
        PSW_OP_NONE = 7'h01,
        PSW_OP_ADD = 7'h02,
        PSW_OP_ADD_WITH_CARRY_OP = 7'h04,
        PSW_OP_SUBTRACT_WITH_BORROW_OP = 7'h08,
        PSW_OP_MUL = 7'h10,
        PSW_OP_DIV = 7'h20,
        PSW_OP_OTHER = 7'h40
    } psw_op_t;
    // One arithmetic result report
    typedef struct packed
    {
        logic valid;
        psw_op_t op;
        logic [7:0] a;
        logic [7:0] b;
        logic cin;
        logic [7:0] prod_hi;
        logic carry_ext;
        logic half_ext;
    } psw_alu_t;
    // One register write from the core
    typedef struct packed
    {
        logic byte_we;
        logic bit_we;
        logic [7:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } psw_wr_t;
endpackage : psw_pkg

// ---- psw_status_word_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "psw_regs.svh"
module psw_status_word_test
    import psw_pkg::*;
;
    // Design inputs
    logic clk_sys_i = 1'b0;
    logic arst_n_i;
    psw_alu_t alu_i;
    logic [7:0] acc_i = 8'h00;
    psw_wr_t wr_i = '0;
    logic [2:0] reg_num_i = 3'h0;
    // Design outputs
    logic [7:0] status_flags_word_o;
    logic [4:0] work_reg_addr_o;
    logic carry_flag_o;
    // Expected flag bits 7:1
    logic [7:0] model_reg = 8'h00;
    int errors = 0;
    int n_checks = 0;
    psw_status_word dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .alu_i(alu_i), .acc_i(acc_i), .wr_i(wr_i),
        .reg_num_i(reg_num_i), .status_flags_word_o(status_flags_word_o), .work_reg_addr_o(work_reg_addr_o),
        .carry_flag_o(carry_flag_o));
    // 25 MHz clock
    initial
    begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    // Compare and count
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // One edge plus input delay
    task automatic settle();
        @(posedge clk_sys_i);
        #1;
    endtask : settle
    // Whole word and carry output against the model
    task automatic check_word();
        check("status word", status_flags_word_o, {model_reg[7:1], ^acc_i});
        check("carry output", {7'h00, carry_flag_o}, {7'h00, model_reg[7]});
    endtask : check_word
    // One arithmetic report, then expected flags
    task automatic alu(input psw_op_t op, input logic [7:0] a, input logic [7:0] b, input logic c,
        input logic [7:0] ph, input logic ext);
        logic [8:0] r;
        logic cx;
        cx = (op == PSW_OP_ADD_WITH_CARRY_OP) ? c : 1'b0;
        alu_i = '{1'b1, op, a, b, c, ph, ext, ext};
        settle();
        alu_i.valid = 1'b0;
        case (op)
            // Add forms: carry, nibble carry, signed wrap
            PSW_OP_ADD, PSW_OP_ADD_WITH_CARRY_OP:
            begin
                r = {1'b0, a} + {1'b0, b} + {8'h00, cx};
                model_reg[7] = r[8];
                model_reg[6] = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cx}) > 5'h0f;
                model_reg[2] = (a[7] == b[7]) && (r[7] != a[7]);
            end
            // Subtract with borrow
            PSW_OP_SUBTRACT_WITH_BORROW_OP:
            begin
                r = {1'b0, a} - {1'b0, b} - {8'h00, c};
                model_reg[7] = r[8];
                model_reg[6] = {1'b0, a[3:0]} < ({1'b0, b[3:0]} + {4'h0, c});
                model_reg[2] = (a[7] != b[7]) && (r[7] != a[7]);
            end
            // Multiply and divide clear carry
            PSW_OP_MUL:
            begin
                model_reg[7] = 1'b0;
                model_reg[6] = 1'b0;
                model_reg[2] = (ph != 8'h00);
            end
            PSW_OP_DIV:
            begin
                model_reg[7] = 1'b0;
                model_reg[6] = 1'b0;
                model_reg[2] = (b == 8'h00);
            end
            // Other ops take external carries
            PSW_OP_OTHER:
            begin
                model_reg[7] = ext;
                model_reg[6] = ext;
            end
            default:
            begin
            end
        endcase
        settle();
        check_word();
    endtask : alu
    // Byte or bit write, then expected word
    task automatic wr(input logic bitw, input logic [7:0] addr, input logic [2:0] sel, input logic [7:0] d);
        wr_i = '{~bitw, bitw, addr, sel, d};
        settle();
        wr_i = '0;
        if (addr == `PSW_ADDR && bitw && sel != 3'h0)
            model_reg[sel] = d[0];
        if (addr == `PSW_ADDR && !bitw)
            model_reg[7:1] = d[7:1];
        settle();
        check_word();
    endtask : wr
    // Verdict
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done
    // Main sequence
    initial
    begin
        arst_n_i = 1'b0;
        alu_i = '{1'b0, PSW_OP_NONE, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0};
        repeat (6) @(posedge clk_sys_i);
        #1;
        arst_n_i = 1'b1;
        settle();
        check_word();
        $display("reset test done");
        alu(PSW_OP_ADD, 8'hff, 8'h01, 1'b1, 8'h00, 1'b0);
        alu(PSW_OP_ADD, 8'h7f, 8'h01, 1'b0, 8'h00, 1'b0);
        alu(PSW_OP_ADD, 8'h01, 8'h02, 1'b0, 8'h00, 1'b0);
        alu(PSW_OP_ADD_WITH_CARRY_OP, 8'h0f, 8'h00, 1'b1, 8'h00, 1'b0);
        alu(PSW_OP_ADD_WITH_CARRY_OP, 8'h80, 8'h7f, 1'b1, 8'h00, 1'b0);
        alu(PSW_OP_ADD_WITH_CARRY_OP, 8'h80, 8'h80, 1'b0, 8'h00, 1'b0);
        alu(PSW_OP_SUBTRACT_WITH_BORROW_OP, 8'h00, 8'h01, 1'b0, 8'h00, 1'b0);
        alu(PSW_OP_SUBTRACT_WITH_BORROW_OP, 8'h80, 8'h01, 1'b0, 8'h00, 1'b0);
        alu(PSW_OP_SUBTRACT_WITH_BORROW_OP, 8'h10, 8'h00, 1'b1, 8'h00, 1'b0);
        alu(PSW_OP_ADD, 8'h01, 8'h01, 1'b0, 8'h00, 1'b0);
        alu(PSW_OP_MUL, 8'h10, 8'h10, 1'b0, 8'h01, 1'b0);
        alu(PSW_OP_MUL, 8'h0f, 8'h0f, 1'b0, 8'h00, 1'b0);
        alu(PSW_OP_DIV, 8'h05, 8'h00, 1'b0, 8'h00, 1'b0);
        alu(PSW_OP_OTHER, 8'h00, 8'h00, 1'b0, 8'h00, 1'b1);
        alu(PSW_OP_NONE, 8'hff, 8'hff, 1'b1, 8'h00, 1'b0);
        alu(PSW_OP_OTHER, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0);
        alu(PSW_OP_DIV, 8'h05, 8'h05, 1'b0, 8'h00, 1'b0);
        $display("arithmetic test done");
        wr(1'b0, `PSW_ADDR, 3'h0, 8'hff);
        wr(1'b0, 8'he0, 3'h0, 8'h00);
        for (int i = 0; i < 8; i++)
            wr(1'b1, `PSW_ADDR, 3'(i), {7'h00, i[0]});
        alu(PSW_OP_ADD, 8'h01, 8'h01, 1'b0, 8'h00, 1'b0);
        wr(1'b0, `PSW_ADDR, 3'h0, 8'h00);
        $display("write test done");
        for (int i = 0; i < 6; i++)
        begin
            acc_i = 8'(8'h01 << i) | 8'(i > 2 ? 8'h40 : 8'h00);
            settle();
            settle();
            check_word();
        end
        $display("parity test done");
        for (int b = 0; b < 4; b++)
        begin
            wr(1'b0, `PSW_ADDR, 3'h0, {3'h0, 2'(b), 3'h0});
            reg_num_i = 3'(7 * (b % 2));
            settle();
            settle();
            check("register address", {3'h0, work_reg_addr_o}, {3'h0, 2'(b), reg_num_i});
        end
        $display("bank test done");
        test_done();
    end
endmodule : psw_status_word_test
`default_nettype wire
